// file: hdl/ssf_consts.svh
// Timing counts and identification constants for the supply status flag bank.
`ifndef SSF_CONSTS_SVH
`define SSF_CONSTS_SVH
`define SSF_CLK_MHZ            50
`define SSF_DEBOUNCE_US        100
`define SSF_DEBOUNCE_CYCLES    (`SSF_DEBOUNCE_US * `SSF_CLK_MHZ)
`define SSF_LONG_LOW_MS        100
`define SSF_LONG_LOW_CYCLES    (`SSF_LONG_LOW_MS * 1000 * `SSF_CLK_MHZ)
`define SSF_CNT_W              23
`define SSF_PART_NUMBER_RESET  2'h0
`define SSF_REVISION_RESET     5'h00
`endif

// file: hdl/ssf_pkg.sv
// Types shared by the supply status flag bank.
package ssf_pkg;
    // Latched condition flags, one bit each.
    typedef struct packed {
        logic thermal_warning;
        logic undervoltage;
        logic overvoltage;
        logic aux_overvoltage;
        logic long_low;
        logic undervoltage_report;
    } ssf_flags_type;
    // Comparator levels from the analog monitors.
    typedef struct packed {
        logic thermal_hot;
        logic main_below_uv;
        logic main_above_ov;
        logic aux_above_ov;
    } ssf_sense_type;
endpackage

// file: hdl/ssf_debounce.sv
// Debounce counter that signals a level held longer than a set number of cycles.
`timescale 1ns/100ps
module ssf_debounce #(
    parameter int unsigned LIMIT = 5000
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic reset,
    // Level in, qualified level out.
    input  wire logic level,
    output logic      held
);
    logic [22:0] count;

    // Counts while the level stands and flags once the limit is passed.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count <= 23'h000000;
            held  <= 1'b0;
        end else if (!level) begin
            count <= 23'h000000;
            held  <= 1'b0;
        end else if (count >= LIMIT[22:0]) begin
            held <= 1'b1;
        end else begin
            count <= count + 23'h000001;
        end
    end
endmodule

// file: hdl/ssf_supply_status_flags.sv
// Supply monitor status flag bank with read-to-clear latches and identification fields.
// Behaviour
// - Thermal warning flag sets on hot sensor; clears when cool and read.
// - Undervoltage flag sets after over 100 us low; clears when good and read.
// - Overvoltage flag sets after over 100 us high; clears when normal and read.
// - Overvoltage turns off first I/O only when enabled by init configuration.
// - Auxiliary overvoltage flag sets after over 100 us; clears when normal and read.
// - Prolonged-low flag sets after over 100 ms low; clears when good and read.
// - Undervoltage report flag sets whenever low; a later read clears it once the supply is good.
// - Read-only five-bit silicon revision field, bits 4 to 0.
// - Read-only two-bit part number field, bits 1 and 0.
// - Read-only variant bit: zero for 3.3 V, one for 5.0 V.
`timescale 1ns/100ps
`include "ssf_consts.svh"
module ssf_supply_status_flags #(
    parameter int unsigned DEBOUNCE_CYCLES = `SSF_DEBOUNCE_CYCLES,
    parameter int unsigned LONG_LOW_CYCLES = `SSF_LONG_LOW_CYCLES,
    parameter logic [1:0]  PART_NUMBER     = `SSF_PART_NUMBER_RESET,
    parameter logic [4:0]  REVISION        = `SSF_REVISION_RESET,
    parameter logic        VARIANT_5V      = 1'b0
) (
    // Clock and reset.
    input  wire logic                  clk,
    input  wire logic                  reset,
    // Analog comparator levels.
    input  wire ssf_pkg::ssf_sense_type sense,
    // Flag read strobe from the serial interface, one cycle per read.
    input  wire logic                  flags_read,
    // Init configuration: overvoltage turns off the first I/O.
    input  wire logic                  io1_off_on_ov_enable,
    // First I/O drive request and gated drive.
    input  wire logic                  io1_request,
    output logic                       io1_enable,
    // Latched flags.
    output ssf_pkg::ssf_flags_type     flags,
    // Identification fields.
    output logic [1:0]                 part_number_field,
    output logic [4:0]                 silicon_revision_field,
    output logic                       variant_5v
);
    logic uv_held;
    logic ov_held;
    logic aux_held;
    logic low_held;

    // Qualifiers for the timed conditions.
    ssf_debounce #(.LIMIT(DEBOUNCE_CYCLES)) u_uv (
        .clk   (clk),
        .reset (reset),
        .level (sense.main_below_uv),
        .held  (uv_held)
    );
    ssf_debounce #(.LIMIT(DEBOUNCE_CYCLES)) u_ov (
        .clk   (clk),
        .reset (reset),
        .level (sense.main_above_ov),
        .held  (ov_held)
    );
    ssf_debounce #(.LIMIT(DEBOUNCE_CYCLES)) u_aux (
        .clk   (clk),
        .reset (reset),
        .level (sense.aux_above_ov),
        .held  (aux_held)
    );
    ssf_debounce #(.LIMIT(LONG_LOW_CYCLES)) u_low (
        .clk   (clk),
        .reset (reset),
        .level (sense.main_below_uv),
        .held  (low_held)
    );

    // Latched flags: a set condition always wins over a read clear.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flags <= '0;
        end else begin
            flags.thermal_warning <= sense.thermal_hot | (flags.thermal_warning & ~flags_read);
            flags.undervoltage    <= uv_held | (flags.undervoltage & ~flags_read);
            flags.overvoltage     <= ov_held | (flags.overvoltage & ~flags_read);
            flags.aux_overvoltage <= aux_held | (flags.aux_overvoltage & ~flags_read);
            flags.long_low        <= low_held | (flags.long_low & ~flags_read);
            flags.undervoltage_report <= sense.main_below_uv | (flags.undervoltage_report & ~flags_read);
        end
    end

    // The first I/O is held off while the qualified overvoltage lasts, if enabled.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            io1_enable <= 1'b0;
        end else begin
            io1_enable <= io1_request & ~(io1_off_on_ov_enable & ov_held);
        end
    end

    // Identification fields are constants registered after reset.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            part_number_field      <= 2'h0;
            silicon_revision_field <= 5'h00;
            variant_5v             <= 1'b0;
        end else begin
            part_number_field      <= PART_NUMBER;
            silicon_revision_field <= REVISION;
            variant_5v             <= VARIANT_5V;
        end
    end
endmodule

// file: verification/ssf_properties.sv
// Concurrent checks on the supply status flag bank ports.
`timescale 1ns/100ps
module ssf_properties #(
    parameter int unsigned D = 8,
    parameter int unsigned L = 40,
    parameter logic [1:0]  P = 2'h0,
    parameter logic [4:0]  R = 5'h00,
    parameter logic        V = 1'b0
) (
    // Ports watched.
    input wire logic                   clk,
    input wire logic                   reset,
    input wire ssf_pkg::ssf_sense_type sense,
    input wire logic                   flags_read,
    input wire logic                   io1_off_on_ov_enable,
    input wire logic                   io1_request,
    input wire logic                   io1_enable,
    input wire ssf_pkg::ssf_flags_type flags,
    input wire logic [1:0]             part_number_field,
    input wire logic [4:0]             silicon_revision_field,
    input wire logic                   variant_5v
);
    // All checks share one clock and reset.
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_thermal_set: assert property (sense.thermal_hot |=> flags.thermal_warning) else $error("warn late.");
    a_uv_delay: assert property ($rose(flags.undervoltage) |-> $past(sense.main_below_uv, D)) else $error("uv early.");
    a_uv_clear: assert property ($fell(flags.undervoltage) |-> $past(flags_read)) else $error("uv cleared.");
    a_ov_delay: assert property ($rose(flags.overvoltage) |-> $past(sense.main_above_ov, D)) else $error("ov early.");
    a_io_pass: assert property (io1_request && !io1_off_on_ov_enable |=> io1_enable) else $error("io off.");
    a_long_delay: assert property ($rose(flags.long_low) |-> $past(sense.main_below_uv, L)) else $error("low early.");
    a_report_set: assert property (sense.main_below_uv |=> flags.undervoltage_report) else $error("report late.");
    a_ids_fixed: assert property (!$past(reset) |-> {part_number_field, silicon_revision_field, variant_5v} == {P, R, V}) else $error("id.");
    c_ov: cover property (flags.overvoltage);
    c_long: cover property (flags.long_low);
    c_read: cover property (flags_read && flags.thermal_warning);
endmodule
bind ssf_supply_status_flags ssf_properties #(.D(DEBOUNCE_CYCLES), .L(LONG_LOW_CYCLES), .P(PART_NUMBER), .R(REVISION),
    .V(VARIANT_5V)) ssf_properties_i (.*);

// file: verification/ssf_host_model.sv
// Host model that turns read requests into flag read strobes one clock later, as long as the request.
`timescale 1ns/100ps
module ssf_host_model (
    // Clock, request in, read strobe out.
    input  wire logic clk,
    input  wire logic go,
    output logic      flags_read = 1'b0
);
    // The read strobe follows the request input one clock edge later.
    always_ff @(posedge clk) begin
        flags_read <= go;
    end
endmodule

// file: verification/ssf_supply_status_flags_test.sv
// Self-checking bench for the supply status flag bank.
`timescale 1ns/100ps
module ssf_supply_status_flags_test;
    logic clk = 0, reset = 1, flags_read, go = 0, cfg = 0, req = 0, io1_enable, v5;
    ssf_pkg::ssf_sense_type sense = '0;
    ssf_pkg::ssf_flags_type flags;
    logic [1:0] pn;
    logic [4:0] rev;
    int bad_count = 0, checks_done = 0, cyc = 0;
    // Rows: sense, hold cycles, read, expected flags.
    logic [23:0] rows [11] = '{24'h802120, 24'h000100, 24'h404001, 24'h40A011, 24'h41E013, 24'h000100,
        24'h20C008, 24'h000008, 24'h000100, 24'h10C104, 24'h000100};
    // Identification values are arbitrary non-zero picks so that a stuck field shows.
    ssf_supply_status_flags #(.DEBOUNCE_CYCLES(8), .LONG_LOW_CYCLES(40), .PART_NUMBER(2'h2), .REVISION(5'h0B),
        .VARIANT_5V(1'b1)) ssf_supply_status_flags_i (.clk(clk),
        .reset(reset), .sense(sense), .flags_read(flags_read), .io1_off_on_ov_enable(cfg), .io1_request(req),
        .io1_enable(io1_enable), .flags(flags), .part_number_field(pn), .silicon_revision_field(rev), .variant_5v(v5));
    ssf_host_model ssf_host_model_i (.clk(clk), .go(go), .flags_read(flags_read));
    // Clock and hang guard.
    always #10 clk = ~clk;
    always @(posedge clk) if (++cyc > 1000) begin bad_count++; end_sim(); end
    task automatic end_sim();
        if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmp(logic [7:0] g, logic [7:0] e);
        checks_done++;
        if (g !== e) begin bad_count++; $display("ERROR %0t got %h want %h", $time, g, e); end
    endtask
    // Hold a sense pattern, optionally read, then check the flags.
    task automatic run(logic [23:0] r);
        sense <= r[23:20];
        repeat (r[19:12]) @(posedge clk);
        go <= r[8];
        @(posedge clk);
        go <= 1'b0;
        repeat (2) @(posedge clk);
        #1 cmp({2'h0, flags}, r[7:0]);
    endtask
    // Rows, then I/O gating, identification and a mid-run reset.
    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        foreach (rows[i]) run(rows[i]);
        req <= 1'b1;
        cfg <= 1'b1;
        sense <= 4'h2;
        repeat (14) @(posedge clk);
        #1 cmp({7'h00, io1_enable}, 8'h00);
        cfg <= 1'b0;
        repeat (2) @(posedge clk);
        #1 cmp({7'h00, io1_enable}, 8'h01);
        cmp({pn, rev, v5}, 8'h97);
        reset <= 1'b1;
        #1 cmp({2'h0, flags}, 8'h00);
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        #1 cmp({2'h0, flags}, 8'h00);
        cmp({pn, rev, v5}, 8'h97);
        end_sim();
    end
endmodule
